// ### inc/pmra_pkg.sv
// pmra_pkg: constants and types of the power monitor register bank and alert logic
// assumes a 50 MHz core clock and a free running link clock that samples the serial pins
// Notes on behaviour
// [RULE_01] config bits 11:9 pick 1,4,16,64,128,256,512 or 1024 averages
// [RULE_02] config bits 8:6 pick bus conversion time, 66 to 8682 us
// [RULE_03] config bits 5:3 pick shunt conversion time, same eight steps
// [RULE_04] config bits 2:0: x00 power-down, 0xx triggered, 1xx continuous; after reset (bits read 111) the code stays idle until a config write
// [RULE_05] shunt result read-only, cleared at reset, bit 15 sign
// [RULE_06] bus result read-only, cleared at reset, bit 15 reads zero
// [RULE_07] current result read-only, cleared at reset, bit 15 sign
// [RULE_08] calibration holds 15 bits, bit 15 reads zero, scales current and power
// [RULE_09] shunt over/under enable alerts when shunt result passes threshold
// [RULE_10] bus over/under enable alerts when bus result passes threshold
// [RULE_11] power over enable alerts when power after bus conversion exceeds threshold
// [RULE_12] ready alert enable drives alert while conversion done flag is set
// [RULE_13] one limit function at a time; function flag tells limit caused alert
// [RULE_14] function flag: latch clears on mask read, transparent on clean conversion
// [RULE_15] done flag sets after conversions and math; old results stay readable
// [RULE_16] done flag clears on non power-down config write or mask read
// [RULE_17] overflow flag sets when current or power arithmetic overflows
// [RULE_18] polarity bit: 0 active-low open drain, 1 active-high
// [RULE_19] transparent alert follows fault; latched alert holds until mask read
// [RULE_20] host never stops right after start; nine clocks then start recover
// [RULE_21] alert response address always acknowledged; data only if alert pending
// [RULE_22] die register: 12-bit die code 15:4, revision 3:0
// [RULE_23] config bit 15 written one resets every register
// [RULE_24] reset bit clears itself and reads zero
// [RULE_25] each triggered config write runs exactly one conversion sequence
// [RULE_26] pointer byte first, then 16-bit words, high byte first
package pmra_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned NS_PER_US     = 1000;
  localparam int unsigned CYC_PER_US    = NS_PER_US / CLK_PERIOD_NS;

  localparam logic [7:0] REG_CFG   = 8'h00;
  localparam logic [7:0] REG_SHUNT = 8'h01;
  localparam logic [7:0] REG_BUS   = 8'h02;
  localparam logic [7:0] REG_PWR   = 8'h03;
  localparam logic [7:0] REG_CUR   = 8'h04;
  localparam logic [7:0] REG_CAL   = 8'h05;
  localparam logic [7:0] REG_MASK  = 8'h06;
  localparam logic [7:0] REG_LIM   = 8'h07;
  localparam logic [7:0] REG_MAKER = 8'hFE;
  localparam logic [7:0] REG_DIE   = 8'hFF;

  localparam logic [15:0] CFG_RESET  = 16'h4127;
  localparam logic [15:0] ZERO_RESET = 16'h0000;
  localparam logic [15:0] MASK_WR    = 16'hFC03;
  localparam int CFG_RST_BIT = 15;
  localparam int AVG_LSB = 9, BCT_LSB = 6, SCT_LSB = 3;
  localparam int M_SOL = 15, M_SUL = 14, M_BOL = 13, M_BUL = 12, M_POL = 11;
  localparam int M_READY_ALERT_ENABLE = 10, M_ALERT_POLARITY_SELECT = 1, M_LEN = 0;

  localparam logic [6:0] ARA_ADDR  = 7'h0C;
  localparam logic [6:0] BASE_ADDR = 7'h40;

  localparam int unsigned CT_US [8] = '{66, 134, 269, 542, 1085, 2170, 4341, 8682};
  localparam int unsigned AVG_SHIFT [8] = '{0, 2, 4, 6, 7, 8, 9, 10};
  localparam int CUR_SHIFT = 11;
  localparam int PWR_SHIFT = 12;

  typedef struct packed {
    logic [15:0] shunt;
    logic [15:0] bus;
  } pmra_meas_s;

  typedef struct packed {
    logic [7:0]  ptr;
    logic [15:0] data;
  } pmra_wr_s;

  typedef enum logic [1:0] {CV_IDLE = 2'b01, CV_RUN = 2'b10} pmra_conv_e;

  typedef enum logic [5:0] {
    LK_IDLE = 6'b000001, LK_ADDR = 6'b000010, LK_PTR  = 6'b000100,
    LK_WDAT = 6'b001000, LK_RDAT = 6'b010000, LK_WAIT = 6'b100000
  } pmra_link_e;
endpackage

// ### rtl/pmra_top.sv
// pmra_top: serial slave, register bank, conversion sequencer and alert logic
// assumes i_meas holds the converter result on i_clk; serial pins run on i_link_clk
`timescale 1ns/1ps
`default_nettype none
module pmra_top #(
  parameter int unsigned P_CYC_PER_US = pmra_pkg::CYC_PER_US,
  parameter logic [15:0] P_MAKER_ID   = 16'h1A2B, // arbitrary value
  parameter logic [11:0] P_DIE_CODE   = 12'h3C4,  // arbitrary value
  parameter logic [3:0]  P_REV_CODE   = 4'h1      // arbitrary value
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_sys_rst,
  input  wire logic                 i_link_clk,
  input  wire logic                 i_scl,
  input  wire logic                 i_sda,
  input  wire logic [3:0]           i_addr_sel,
  input  wire pmra_pkg::pmra_meas_s i_meas,
  output logic                      o_sda_out,
  output logic                      o_sda_oe,
  output logic                      o_alert_out,
  output logic                      o_alert_oe,
  output logic                      o_adc_run
);
  import pmra_pkg::*;

  if (P_CYC_PER_US < 1 || P_CYC_PER_US > 200) begin : g_bad_rate
    $error("P_CYC_PER_US out of range");
  end

  // ******************************************
  // link domain: pin synchronisers
  // ******************************************
  logic [1:0] rst_pipe_reg;
  logic [2:0] scl_pipe_reg;
  logic [2:0] sda_pipe_reg;
  logic [7:0] addr_pipe_reg;
  logic [1:0] pend_pipe_reg;
  logic [2:0] rdack_pipe_reg;
  logic       lk_rst;
  logic       scl_s;
  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;

  always_ff @(posedge i_link_clk) begin
    rst_pipe_reg   <= {rst_pipe_reg[0], i_sys_rst};
    scl_pipe_reg   <= {scl_pipe_reg[1:0], i_scl};
    sda_pipe_reg   <= {sda_pipe_reg[1:0], i_sda};
    addr_pipe_reg  <= {addr_pipe_reg[3:0], i_addr_sel};
  end

  assign lk_rst    = rst_pipe_reg[1];
  assign scl_s     = scl_pipe_reg[1];
  assign sda_s     = sda_pipe_reg[1];
  assign scl_rise  = scl_s & ~scl_pipe_reg[2];
  assign scl_fall  = ~scl_s & scl_pipe_reg[2];
  assign start_det = scl_s & scl_pipe_reg[2] & sda_pipe_reg[2] & ~sda_s;
  assign stop_det  = scl_s & scl_pipe_reg[2] & ~sda_pipe_reg[2] & sda_s;

  // ******************************************
  // link domain: byte engine
  // ******************************************
  pmra_link_e  lk_state_reg;
  logic [3:0]  cnt_reg;
  logic [7:0]  sh_reg;
  logic [7:0]  tx_reg;
  logic [7:0]  ptr_reg;
  logic [15:0] rd_word_reg;
  pmra_wr_s    wr_reg;
  logic        oe_reg;
  logic        rw_reg;
  logic        ara_reg;
  logic        hi_reg;
  logic        wr_tog_reg;
  logic        rd_tog_reg;
  logic        sda_zero_reg;
  logic [6:0]  own_addr;
  logic        addr_hit;
  logic        ara_hit;
  logic [7:0]  tx_next;
  logic [15:0] core_rd_reg;
  logic        rdack_tog_reg;
  logic        alert_act_reg;

  assign own_addr = BASE_ADDR | {3'h0, addr_pipe_reg[7:4]};
  assign addr_hit = sh_reg[7:1] == own_addr;
  assign ara_hit  = sh_reg[7:1] == ARA_ADDR && sh_reg[0];

  // alert response sends its address only while pending, else releases [RULE_21]
  assign tx_next = ara_reg ? ((pend_pipe_reg[1] && hi_reg) ? {own_addr, 1'b0} : 8'hFF)
                           : (hi_reg ? rd_word_reg[15:8] : rd_word_reg[7:0]); // [RULE_26]

  always_ff @(posedge i_link_clk) begin
    pend_pipe_reg  <= {pend_pipe_reg[0], alert_act_reg};
    rdack_pipe_reg <= {rdack_pipe_reg[1:0], rdack_tog_reg};
    if (rdack_pipe_reg[2] != rdack_pipe_reg[1]) begin
      rd_word_reg <= core_rd_reg;
    end
    sda_zero_reg <= 1'b0;
  end

  always_ff @(posedge i_link_clk) begin
    if (lk_rst) begin
      lk_state_reg <= LK_IDLE;
      cnt_reg      <= 4'h0;
      sh_reg       <= 8'h00;
      tx_reg       <= 8'h00;
      ptr_reg      <= 8'h00;
      wr_reg       <= '0;
      oe_reg       <= 1'b0;
      rw_reg       <= 1'b0;
      ara_reg      <= 1'b0;
      hi_reg       <= 1'b0;
      wr_tog_reg   <= 1'b0;
      rd_tog_reg   <= 1'b0;
    end else if (start_det) begin
      // any start reframes, so nine clocks then start always recover [RULE_20]
      lk_state_reg <= LK_ADDR;
      cnt_reg      <= 4'h0;
      oe_reg       <= 1'b0;
    end else if (stop_det) begin
      lk_state_reg <= LK_IDLE;
      oe_reg       <= 1'b0;
    end else if (scl_rise && !(lk_state_reg inside {LK_IDLE, LK_WAIT})) begin
      cnt_reg <= cnt_reg + 4'h1;
      sh_reg  <= {sh_reg[6:0], sda_s};
      if (lk_state_reg == LK_RDAT && cnt_reg == 4'h8 && sda_s) begin
        lk_state_reg <= LK_WAIT;
      end
    end else if (scl_fall && !(lk_state_reg inside {LK_IDLE, LK_WAIT})) begin
      if (cnt_reg == 4'h8 && lk_state_reg != LK_RDAT) begin
        oe_reg <= 1'b1;
        hi_reg <= 1'b1;
        if (lk_state_reg == LK_ADDR) begin
          rw_reg  <= sh_reg[0];
          ara_reg <= ~addr_hit;
          if (!addr_hit && !ara_hit) begin
            oe_reg       <= 1'b0;
            lk_state_reg <= LK_WAIT;
          end else if (addr_hit && sh_reg[0]) begin
            rd_tog_reg <= ~rd_tog_reg;
          end
        end else if (lk_state_reg == LK_PTR) begin
          ptr_reg <= sh_reg; // [RULE_26]
        end else if (hi_reg) begin
          wr_reg.data[15:8] <= sh_reg;
          hi_reg            <= 1'b0;
        end else begin
          wr_reg.data[7:0] <= sh_reg;
          wr_reg.ptr       <= ptr_reg;
          wr_tog_reg       <= ~wr_tog_reg;
        end
      end else if (cnt_reg == 4'h8) begin
        oe_reg <= 1'b0;
      end else if (cnt_reg == 4'h9) begin
        cnt_reg <= 4'h0;
        oe_reg  <= 1'b0;
        if (lk_state_reg == LK_PTR) begin
          lk_state_reg <= LK_WDAT;
        end else if (lk_state_reg == LK_ADDR && !rw_reg) begin
          lk_state_reg <= LK_PTR;
        end else if (lk_state_reg != LK_WDAT) begin
          lk_state_reg <= LK_RDAT;
          tx_reg       <= tx_next;
          oe_reg       <= ~tx_next[7];
          hi_reg       <= ara_reg ? 1'b0 : ~hi_reg;
        end
      end else if (lk_state_reg == LK_RDAT && cnt_reg != 4'h0) begin
        oe_reg <= ~tx_reg[3'h7 - cnt_reg[2:0]];
      end
    end
  end

  assign o_sda_oe  = oe_reg;
  assign o_sda_out = sda_zero_reg;

  // ******************************************
  // core domain: crossings in
  // ******************************************
  logic [2:0] wr_pipe_reg;
  logic [2:0] rd_pipe_reg;
  logic       wr_evt;
  logic       rd_evt;
  logic       cfg_wr;
  logic       soft_rst;
  logic       rst_any;
  logic       mask_rd;
  logic       wr_pdn;

  always_ff @(posedge i_clk) begin
    wr_pipe_reg <= {wr_pipe_reg[1:0], wr_tog_reg};
    rd_pipe_reg <= {rd_pipe_reg[1:0], rd_tog_reg};
  end

  assign wr_evt   = (wr_pipe_reg[2] != wr_pipe_reg[1]) && !i_sys_rst;
  assign rd_evt   = (rd_pipe_reg[2] != rd_pipe_reg[1]) && !i_sys_rst;
  assign cfg_wr   = wr_evt && wr_reg.ptr == REG_CFG;
  assign soft_rst = cfg_wr && wr_reg.data[CFG_RST_BIT]; // [RULE_23]
  assign rst_any  = i_sys_rst | soft_rst;
  assign mask_rd  = rd_evt && ptr_reg == REG_MASK;
  assign wr_pdn   = wr_reg.data[1:0] == 2'h0; // [RULE_04]

  // ******************************************
  // core domain: register bank
  // ******************************************
  logic [15:0] cfg_reg;
  logic [15:0] cal_reg;
  logic [15:0] mask_reg;
  logic [15:0] lim_reg;

  always_ff @(posedge i_clk) begin
    if (rst_any) begin
      cfg_reg  <= CFG_RESET; // reset bit never stored [RULE_24]
      cal_reg  <= ZERO_RESET;
      mask_reg <= ZERO_RESET;
      lim_reg  <= ZERO_RESET;
    end else if (wr_evt) begin
      unique case (wr_reg.ptr)
        REG_CFG:  cfg_reg  <= {1'b0, wr_reg.data[14:0]};
        REG_CAL:  cal_reg  <= {1'b0, wr_reg.data[14:0]}; // [RULE_08]
        REG_MASK: mask_reg <= wr_reg.data & MASK_WR;
        REG_LIM:  lim_reg  <= wr_reg.data;
        default:  cal_reg  <= cal_reg;
      endcase
    end
  end

  // ******************************************
  // core domain: conversion sequencer
  // ******************************************
  function automatic logic [31:0] conv_cycles(input logic [15:0] c);
    logic [31:0] t;
    t = 32'(c[0] ? CT_US[c[SCT_LSB +: 3]] : 0) + 32'(c[1] ? CT_US[c[BCT_LSB +: 3]] : 0);
    return 32'(t * P_CYC_PER_US) << AVG_SHIFT[c[AVG_LSB +: 3]]; // [RULE_01] [RULE_02] [RULE_03]
  endfunction

  pmra_conv_e  cv_state_reg;
  logic [31:0] cv_cnt_reg;
  logic        conv_done;
  logic        adc_run_reg;

  assign conv_done = cv_state_reg == CV_RUN && cv_cnt_reg == 32'h1 && !cfg_wr;

  always_ff @(posedge i_clk) begin
    if (rst_any) begin
      cv_state_reg <= CV_IDLE;
      cv_cnt_reg   <= 32'h0;
    end else if (cfg_wr) begin
      cv_state_reg <= wr_pdn ? CV_IDLE : CV_RUN; // [RULE_25]
      cv_cnt_reg   <= conv_cycles(wr_reg.data);
    end else if (conv_done) begin
      cv_state_reg <= cfg_reg[2] ? CV_RUN : CV_IDLE; // [RULE_04] [RULE_25]
      cv_cnt_reg   <= conv_cycles(cfg_reg);
    end else if (cv_state_reg == CV_RUN) begin
      cv_cnt_reg <= cv_cnt_reg - 32'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    adc_run_reg <= !i_sys_rst && cv_state_reg == CV_RUN;
  end
  assign o_adc_run = adc_run_reg;

  // ******************************************
  // core domain: results and arithmetic
  // ******************************************
  logic [15:0]        shunt_reg;
  logic [15:0]        bus_reg;
  logic [15:0]        cur_reg;
  logic [15:0]        pwr_reg;
  logic [15:0]        sh_new;
  logic [15:0]        bus_new;
  logic signed [31:0] cur_full;
  logic [15:0]        cur_mag;
  logic [31:0]        pwr_full;
  logic               math_ovf;

  assign sh_new   = cfg_reg[0] ? i_meas.shunt : shunt_reg;
  assign bus_new  = cfg_reg[1] ? {1'b0, i_meas.bus[14:0]} : bus_reg; // [RULE_06]
  assign cur_full = ($signed({{16{sh_new[15]}}, sh_new}) *
                     $signed({17'h00000, cal_reg[14:0]})) >>> CUR_SHIFT; // [RULE_08]
  assign cur_mag  = cur_full[15] ? 16'(-cur_full[15:0]) : cur_full[15:0];
  assign pwr_full = ({16'h0000, cur_mag} * {17'h00000, bus_new[14:0]}) >> PWR_SHIFT;
  assign math_ovf = (cur_full[31:15] != {17{cur_full[15]}}) || (|pwr_full[31:16]); // [RULE_17]

  always_ff @(posedge i_clk) begin
    if (rst_any) begin
      shunt_reg <= ZERO_RESET;
      bus_reg   <= ZERO_RESET;
      cur_reg   <= ZERO_RESET;
      pwr_reg   <= ZERO_RESET;
    end else if (conv_done) begin
      shunt_reg <= sh_new; // [RULE_05]
      bus_reg   <= bus_new;
      cur_reg   <= cur_full[15:0]; // [RULE_07]
      pwr_reg   <= pwr_full[15:0];
    end
  end

  // ******************************************
  // core domain: flags and alert
  // ******************************************
  logic aff_reg;
  logic conversion_done_flag_reg;
  logic ovf_reg;
  logic alert_oe_reg;
  logic alert_zero_reg;
  logic cond;

  always_comb begin
    cond = 1'b0;
    // first enabled limit function wins, only one compares [RULE_13]
    if (mask_reg[M_SOL]) begin
      cond = cfg_reg[0] && $signed(sh_new) > $signed(lim_reg); // [RULE_09]
    end else if (mask_reg[M_SUL]) begin
      cond = cfg_reg[0] && $signed(sh_new) < $signed(lim_reg); // [RULE_09]
    end else if (mask_reg[M_BOL]) begin
      cond = cfg_reg[1] && bus_new > lim_reg; // [RULE_10]
    end else if (mask_reg[M_BUL]) begin
      cond = cfg_reg[1] && bus_new < lim_reg; // [RULE_10]
    end else if (mask_reg[M_POL]) begin
      cond = cfg_reg[1] && pwr_full[15:0] > lim_reg; // [RULE_11]
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst_any) begin
      aff_reg <= 1'b0;
    end else if (conv_done && cond) begin
      aff_reg <= 1'b1;
    end else if (conv_done && !mask_reg[M_LEN]) begin
      aff_reg <= 1'b0; // [RULE_14] [RULE_19]
    end else if (mask_rd && mask_reg[M_LEN]) begin
      aff_reg <= 1'b0; // [RULE_14] [RULE_19]
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst_any) begin
      conversion_done_flag_reg <= 1'b0;
    end else if (conv_done) begin
      conversion_done_flag_reg <= 1'b1; // [RULE_15]
    end else if ((cfg_wr && !wr_pdn) || mask_rd) begin
      conversion_done_flag_reg <= 1'b0; // [RULE_16]
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst_any) begin
      ovf_reg <= 1'b0;
    end else if (conv_done) begin
      ovf_reg <= math_ovf; // [RULE_17]
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst_any) begin
      alert_act_reg  <= 1'b0;
      alert_oe_reg   <= 1'b0;
      alert_zero_reg <= 1'b0;
    end else begin
      alert_act_reg <= aff_reg | (mask_reg[M_READY_ALERT_ENABLE] & conversion_done_flag_reg); // [RULE_12]
      alert_oe_reg  <= (aff_reg | (mask_reg[M_READY_ALERT_ENABLE] & conversion_done_flag_reg)) ^ mask_reg[M_ALERT_POLARITY_SELECT]; // [RULE_18]
    end
  end
  assign o_alert_oe  = alert_oe_reg;
  assign o_alert_out = alert_zero_reg;

  // ******************************************
  // core domain: read answer
  // ******************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      core_rd_reg   <= ZERO_RESET;
      rdack_tog_reg <= 1'b0;
    end else if (rd_evt) begin
      rdack_tog_reg <= ~rdack_tog_reg;
      unique case (ptr_reg)
        REG_CFG:   core_rd_reg <= cfg_reg;
        REG_SHUNT: core_rd_reg <= shunt_reg;
        REG_BUS:   core_rd_reg <= bus_reg;
        REG_PWR:   core_rd_reg <= pwr_reg;
        REG_CUR:   core_rd_reg <= cur_reg;
        REG_CAL:   core_rd_reg <= cal_reg;
        REG_MASK:  core_rd_reg <= {mask_reg[15:10], 5'h00, aff_reg, conversion_done_flag_reg, ovf_reg,
                                   mask_reg[1:0]};
        REG_LIM:   core_rd_reg <= lim_reg;
        REG_MAKER: core_rd_reg <= P_MAKER_ID;
        REG_DIE:   core_rd_reg <= {P_DIE_CODE, P_REV_CODE}; // [RULE_22]
        default:   core_rd_reg <= ZERO_RESET;
      endcase
    end
  end

  // ******************************************
  // checks
  // ******************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  chk_soft_reset: assert property ( // [RULE_23]
    soft_rst |=> cfg_reg == CFG_RESET && mask_reg == ZERO_RESET && cal_reg == ZERO_RESET)
    else $error("register reset did not restore reset values");
  chk_rst_bit_zero: assert property (!cfg_reg[CFG_RST_BIT]) // [RULE_24]
    else $error("reset bit reads one");
  chk_done_sets: assert property (conv_done |=> conversion_done_flag_reg ##1 $stable(shunt_reg)) // [RULE_15]
    else $error("done flag not set after conversion");
  chk_done_clears: assert property ( // [RULE_16]
    (mask_rd || (cfg_wr && !wr_pdn && !soft_rst)) && !conv_done |=> !conversion_done_flag_reg)
    else $error("done flag not cleared");
  chk_latch_hold: assert property ( // [RULE_14]
    aff_reg && mask_reg[M_LEN] && !mask_rd && !soft_rst |=> aff_reg)
    else $error("latched function flag dropped without a read");
  chk_trig_once: assert property ( // [RULE_25]
    conv_done && !cfg_reg[2] |=> cv_state_reg == CV_IDLE
    ##1 (cv_state_reg == CV_IDLE || $past(cfg_wr)))
    else $error("triggered mode ran a second sequence");
  chk_alert_low: assert property ( // [RULE_18]
    aff_reg && !mask_reg[M_ALERT_POLARITY_SELECT] && !soft_rst |=> o_alert_oe)
    else $error("active-low alert not driven");
  chk_ready_alert: assert property ( // [RULE_12]
    mask_reg[M_READY_ALERT_ENABLE] && conversion_done_flag_reg && !soft_rst |=> alert_act_reg)
    else $error("ready alert not raised");
  chk_bus_top: assert property (!bus_reg[15] && !cal_reg[15]) // [RULE_06]
    else $error("reserved top bit set");
  chk_ovf_flag: assert property (conv_done && math_ovf |=> ovf_reg) // [RULE_17]
    else $error("overflow not flagged");
  chk_ack_addr: assert property ( // [RULE_21]
    @(posedge i_link_clk) disable iff (lk_rst)
    scl_fall && lk_state_reg == LK_ADDR && cnt_reg == 4'h8 && !start_det && !stop_det
    && (addr_hit || ara_hit) |=> oe_reg)
    else $error("own or alert response address not acknowledged");

  cov_conv_done: cover property (conv_done ##[1:8] mask_rd);
  cov_latched_alert: cover property (aff_reg && mask_reg[M_LEN] ##1 mask_rd);
  cov_ara_read: cover property (@(posedge i_link_clk) lk_state_reg == LK_RDAT && ara_reg);
  cov_cfg_write: cover property (cfg_wr && !wr_pdn);
endmodule // pmra_top
`default_nettype wire

// ### sim/pmra_host.sv
// pmra_host: behavioural serial host that drives the monitor's clock and data pins
// assumes the bench resolves the pulled-up data wire and runs i_clk at 20 ns
`timescale 1ns/1ps
`default_nettype none
module pmra_host #(
  parameter logic [6:0] P_ADDR = 7'h43
) (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  logic [7:0] cur_ptr = 8'hAA;
  logic [7:0] naks    = 8'h00;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // ********************************
  // bit and byte framing
  // ********************************
  // quarter bit; each clock phase spans two, above sixteen link clocks
  task automatic q();
    repeat (52) @(negedge i_clk);
  endtask
  task automatic bit_x(input logic b, output logic r);
    o_sda_low = ~b;
    q();
    o_scl = 1'b1;
    q();
    r = i_sda;
    q();
    o_scl = 1'b0;
    q();
  endtask
  // a start is always followed by a whole byte, never by a stop
  task automatic start();
    o_sda_low = 1'b0;
    q();
    o_scl = 1'b1;
    q();
    o_sda_low = 1'b1;
    q();
    o_scl = 1'b0;
    q();
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    q();
    o_scl = 1'b1;
    q();
    o_sda_low = 1'b0;
    q();
  endtask
  // most significant bit first, then the acknowledge slot
  task automatic byte_x(input logic [7:0] d, input logic a_in, output logic [7:0] r,
                        output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
    bit_x(a_in, a);
  endtask
  task automatic send(input logic [7:0] d);
    logic [7:0] r;
    logic       a;
    byte_x(d, 1'b1, r, a);
    if (a !== 1'b0) naks = naks + 8'h01;
  endtask
  // pointer byte first, then high byte and low byte
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    start();
    send({P_ADDR, 1'b0});
    send(p);
    send(d[15:8]);
    send(d[7:0]);
    stop();
    cur_ptr = p;
  endtask
  task automatic rd(input logic [7:0] p, output logic [15:0] d);
    logic [7:0] hi;
    logic [7:0] lo;
    logic       a;
    if (p !== cur_ptr) begin
      start();
      send({P_ADDR, 1'b0});
      send(p);
      stop();
      cur_ptr = p;
    end
    start();
    send({P_ADDR, 1'b1});
    byte_x(8'hFF, 1'b0, hi, a);
    byte_x(8'hFF, 1'b1, lo, a);
    stop();
    d = {hi, lo};
  endtask
  // alert reply: takes whatever byte comes, all ones if none is sent
  task automatic ara(output logic [7:0] b);
    logic a;
    start();
    send(8'h19);
    byte_x(8'hFF, 1'b1, b, a);
    stop();
  endtask
endmodule // pmra_host
`default_nettype wire

// ### sim/power_monitor_register_alert_logic_bench.sv
// power_monitor_register_alert_logic_bench: self-checking bench of the monitor
// assumes pmra_top and pmra_host; strap code 3 gives serial address 0x43
`timescale 1ns/1ps
`default_nettype none
module power_monitor_register_alert_logic_bench;
  import pmra_pkg::*;
  localparam int unsigned LIMIT = 130000;
  localparam logic [11:0] DIE   = 12'h5A6; // arbitrary value
  localparam logic [3:0]  REV   = 4'h9;    // arbitrary value
  logic        i_clk      = 1'b0;
  logic        i_sys_rst  = 1'b1;
  logic        i_link_clk = 1'b0;
  pmra_meas_s  i_meas     = '{shunt: 16'h8005, bus: 16'h8123};
  logic        scl, sda_low, sda_oe, alert_oe, adc_run, sda_out, alert_out;
  wire         sda = ~(sda_low | sda_oe);
  int unsigned failures = 0, checked = 0, cycles = 0;
  logic [15:0] v;
  logic [7:0]  b;
  always #10 i_clk = ~i_clk;
  initial begin
    #7;
    forever #62.5 i_link_clk = ~i_link_clk;
  end
  pmra_top #(.P_CYC_PER_US(1), .P_DIE_CODE(DIE), .P_REV_CODE(REV)) u_pmra_top (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_link_clk(i_link_clk), .i_scl(scl),
    .i_sda(sda), .i_addr_sel(4'h3), .i_meas(i_meas), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .o_alert_out(alert_out), .o_alert_oe(alert_oe), .o_adc_run(adc_run));
  pmra_host #(.P_ADDR(7'h43)) u_pmra_host (
    .i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  // ********************************
  // checking and closing
  // ********************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      give_verdict();
    end
  end
  task automatic wait_oe(input logic lvl);
    for (int i = 0; i < 600 && alert_oe !== lvl; i++) @(negedge i_clk);
  endtask
  // ********************************
  // scenarios
  // ********************************
  task automatic t_reset();
    check("alert idle", alert_oe, 1'b0);
    check("pin levels", {sda_out, alert_out}, 2'b00);
    check("idle after reset", adc_run, 1'b0);
    u_pmra_host.rd(REG_CFG, v);
    check("cfg reset", v, CFG_RESET);
    u_pmra_host.rd(REG_DIE, v);
    check("die id", v, {DIE, REV});
    $display("test reset done");
  endtask
  task automatic t_convert();
    // bus over limit against a zero limit, ready alert on, latched
    u_pmra_host.wr(REG_MASK, 16'h2401);
    u_pmra_host.wr(REG_CFG, 16'h0003);
    wait_oe(1'b1);
    check("alert raised", alert_oe, 1'b1);
    repeat (300) @(negedge i_clk);
    check("single run", adc_run, 1'b0);
    u_pmra_host.rd(REG_SHUNT, v);
    check("shunt result", v, 16'h8005);
    u_pmra_host.rd(REG_BUS, v);
    check("bus result", v, 16'h0123);
    u_pmra_host.ara(b);
    check("alert reply", b, {7'h43, 1'b0});
    u_pmra_host.rd(REG_MASK, v);
    check("mask upper", v[15:4], 12'h241);
    check("mask flags", v[3:0], 4'h9);
    wait_oe(1'b0);
    check("alert cleared", alert_oe, 1'b0);
    $display("test convert done");
  endtask
  task automatic t_soft();
    u_pmra_host.wr(REG_CAL, 16'hFFFF);
    u_pmra_host.rd(REG_CAL, v);
    check("cal top bit", v, 16'h7FFF);
    u_pmra_host.wr(REG_CFG, 16'h8000);
    u_pmra_host.rd(REG_CFG, v);
    check("cfg after reset", v, CFG_RESET);
    u_pmra_host.rd(REG_CAL, v);
    check("cal after reset", v, 16'h0000);
    check("acks", u_pmra_host.naks, 8'h00);
    $display("test soft reset done");
  endtask
  initial begin
    // link reset passes two flops, so hold past four link clocks
    repeat (30) @(negedge i_clk);
    i_sys_rst = 1'b0;
    repeat (10) @(negedge i_clk);
    t_reset();
    t_convert();
    t_soft();
    give_verdict();
  end
endmodule // power_monitor_register_alert_logic_bench
`default_nettype wire
